// ### rtl/fsr_regs.v
// Register access over Wishbone was chosen for this implementation.
`include "fsr_consts.vh"

module fsr_regs #(
  parameter DTYPE_RST = 8'h00,                // Drive type config reset
  parameter BOOT_RST  = 8'h00                 // Boot drive config reset
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Tristate mask of byte 0 on reads (1 = bit driven)
  output reg  [7:0]  rd_drive_o,
  // Status inputs from the command engine
  input  wire [3:0]  seek_busy_i,
  input  wire        cmd_busy_i,
  input  wire        non_dma_exec_i,
  input  wire        xfer_dir_i,
  input  wire        host_req_i,
  // Mode and identity option
  input  wire        enh_mode2_i,
  input  wire        ident_i,
  input  wire [1:0]  drive_sel_i,             // Last drive selected by output register
  input  wire        data_access_i,           // Pulse on data register access
  input  wire        dor_reset_i,             // Pulse on output register soft reset
  // Outputs to drives and core
  output reg         density_o,
  output reg  [1:0]  rate_sel_o,
  output reg  [2:0]  data_rate_o,
  output reg  [7:0]  precomp_steps_o,         // Delay in clock-derived units of 41.67 ns
  output reg  [7:0]  precomp_track_o,
  output reg         low_power_o,
  output reg         soft_reset_o
);

  // Registers
  reg  [7:0] rate_q;                          // Rate/precomp register
  reg  [1:0] act_sel_q;                       // Active rate select
  reg  [1:0] tape_q;                          // Tape select bits
  reg  [7:0] dtype_q;                         // Drive type config
  reg  [7:0] boot_q;                          // Boot drive config
  reg  [1:0] drt_q;                           // Drive rate config
  reg  [7:0] track_q;                         // Precomp start track
  reg        ack_q;

  // Access qualifiers
  wire       req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire       wr    = req & wb_we_i & wb_sel_i[0];
  wire       rd    = req & ~wb_we_i;
  wire [3:0] idx   = wb_adr_i[5:2];

  // Decode of rate from drive rate and select
  function [2:0] fsr_rate;
    input [1:0] drt;
    input [1:0] sel;
    begin
      case (sel)
        2'b11:   fsr_rate = `FSR_R1M;
        2'b00:   fsr_rate = `FSR_R500;
        2'b10:   fsr_rate = `FSR_R250;
        default: fsr_rate = (drt == 2'b01) ? `FSR_R500 :
                            (drt == 2'b10) ? `FSR_R2M : `FSR_R300;
      endcase
    end
  endfunction

  wire [2:0] rate_now = fsr_rate(drt_q, act_sel_q);
  wire [2:0] pc_code  = rate_q[4:2];

  // Status byte composition
  wire [7:0] status_b = {host_req_i, xfer_dir_i, non_dma_exec_i, cmd_busy_i, seek_busy_i};

  // Tape register byte by mode
  wire [7:0] tape_b = enh_mode2_i ?
                      {2'b00, dtype_q[{drive_sel_i, 1'b1}], dtype_q[{drive_sel_i, 1'b0}],
                       boot_q[1], boot_q[0], tape_q} :
                      {6'h00, tape_q};

  // Bus slave; unmapped reads give zero, writes ignored
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q      <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      rd_drive_o <= 8'hff;
    end else begin
      ack_q      <= req;
      wb_ack_o   <= req;
      if (rd) begin
        case (idx)
          `FSR_IDX_TAPE: begin
            wb_dat_o   <= {24'h000000, tape_b};
            rd_drive_o <= enh_mode2_i ? 8'hff : 8'h03;
          end
          `FSR_IDX_STATUS: begin
            wb_dat_o   <= {24'h000000, status_b};
            rd_drive_o <= 8'hff;
          end
          `FSR_IDX_CFG: begin
            wb_dat_o   <= {8'h00, track_q, 6'h00, drt_q, 8'h00};
            rd_drive_o <= 8'hff;
          end
          `FSR_IDX_STRAP: begin
            wb_dat_o   <= {16'h0000, boot_q, dtype_q};
            rd_drive_o <= 8'hff;
          end
          default: begin
            wb_dat_o   <= 32'h00000000;
            rd_drive_o <= 8'hff;
          end
        endcase
      end
    end
  end

  // Register writes; soft reset leaves everything here untouched
  always @(posedge clk_i) begin
    if (rst_i) begin
      rate_q    <= `FSR_RATE_RESET;
      act_sel_q <= 2'b10;
      tape_q    <= 2'b00;
      dtype_q   <= DTYPE_RST;
      boot_q    <= BOOT_RST;
      drt_q     <= 2'b00;
      track_q   <= 8'h00;
    end else if (wr) begin
      case (idx)
        `FSR_IDX_TAPE: tape_q <= wb_dat_i[1:0];
        `FSR_IDX_RATE: begin
          // Self-clearing reset bit is not stored
          rate_q    <= {1'b0, wb_dat_i[6:0]};
          act_sel_q <= wb_dat_i[1:0];
        end
        `FSR_IDX_CCR: act_sel_q <= wb_dat_i[1:0];
        `FSR_IDX_CFG: begin
          if (wb_sel_i[1]) drt_q <= wb_dat_i[9:8];
          if (wb_sel_i[2]) track_q <= wb_dat_i[23:16];
        end
        `FSR_IDX_STRAP: begin
          dtype_q <= wb_dat_i[7:0];
          if (wb_sel_i[1]) boot_q <= wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end else if (req & wb_we_i & wb_sel_i[1]) begin
      // Lane 1 of config registers without byte 0
      if (idx == `FSR_IDX_CFG) drt_q <= wb_dat_i[9:8];
      if (idx == `FSR_IDX_STRAP) boot_q <= wb_dat_i[15:8];
    end
  end

  // Low power, soft reset pulse and decoded outputs
  wire rate_wr  = wr & (idx == `FSR_IDX_RATE);
  wire stat_rd  = rd & (idx == `FSR_IDX_STATUS);
  always @(posedge clk_i) begin
    if (rst_i) begin
      low_power_o     <= 1'b0;
      soft_reset_o    <= 1'b0;
      density_o       <= 1'b1;
      rate_sel_o      <= 2'b10;
      data_rate_o     <= `FSR_R250;
      precomp_steps_o <= 8'h03;
      precomp_track_o <= 8'h00;
    end else begin
      soft_reset_o <= rate_wr & wb_dat_i[`FSR_BIT_SWRST];
      // Any exit event wins over an entry in the same cycle; a soft reset in the same write clears it a cycle later
      if (soft_reset_o | dor_reset_i | data_access_i | stat_rd)
        low_power_o <= 1'b0;
      else if (rate_wr & wb_dat_i[`FSR_BIT_LOWPWR])
        low_power_o <= 1'b1;
      // Density ignores soft resets; driven by select and identity
      density_o   <= ~(act_sel_q[0] ^ act_sel_q[1]) ^ ~ident_i;
      rate_sel_o  <= act_sel_q;
      data_rate_o <= rate_now;
      precomp_track_o <= track_q;
      // Delay in 41.67 ns steps: 7 off, 0 default by rate
      if (pc_code == 3'h7)
        precomp_steps_o <= 8'h00;
      else if (pc_code == 3'h0)
        precomp_steps_o <= (rate_now == `FSR_R1M) ? 8'h01 : 8'h03;
      else
        precomp_steps_o <= {5'h00, pc_code};
    end
  end

endmodule // fsr_regs

// ### inc/fsr_consts.vh
`ifndef FSR_CONSTS_VH
`define FSR_CONSTS_VH
// Word indexes; byte address is four times the index
`define FSR_IDX_TAPE      4'h3
`define FSR_IDX_STATUS    4'h4
`define FSR_IDX_RATE      4'h4
`define FSR_IDX_CCR       4'h7
`define FSR_IDX_CFG       4'h8
`define FSR_IDX_STRAP     4'h9
// Rate register fields and reset value
`define FSR_RATE_RESET    8'h02
`define FSR_BIT_SWRST     7
`define FSR_BIT_LOWPWR    6
`define FSR_BIT_UNDEF     5
// Rate codes on the active-rate output
`define FSR_R250          3'h0
`define FSR_R300          3'h1
`define FSR_R500          3'h2
`define FSR_R1M           3'h3
`define FSR_R2M           3'h4
// Precompensation step in picoseconds and clock period in picoseconds
`define FSR_PRECOMP_STEP_PS 41670
`define FSR_CLK_PS        40000
`endif

// ### tb/fsr_regs_checker.sv
module fsr_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  rd_drive_o,
  input wire logic [3:0]  seek_busy_i,
  input wire logic        cmd_busy_i,
  input wire logic        non_dma_exec_i,
  input wire logic        xfer_dir_i,
  input wire logic        host_req_i,
  input wire logic        enh_mode2_i,
  input wire logic        data_access_i,
  input wire logic [1:0]  rate_sel_o,
  input wire logic [2:0]  data_rate_o,
  input wire logic [7:0]  precomp_steps_o,
  input wire logic        low_power_o,
  input wire logic        soft_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Request taken: cycle open and no ack pending
  wire tk  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Taken byte-0 write to the rate register slot
  wire wr4 = tk & wb_we_i & (wb_adr_i[5:2] == 4'h4) & wb_sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (tk |=> wb_ack_o) else $error("ack missing");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_rate_sel_copy: assert property (wr4 |=> ##[0:1] rate_sel_o == $past(wb_dat_i[1:0]))
    else $error("rate select not copied");
  a_swrst_pulse: assert property (wr4 && wb_dat_i[7] |-> ##[1:2] soft_reset_o) else $error("no reset");
  a_swrst_clears: assert property (soft_reset_o |=> !soft_reset_o) else $error("reset stuck");
  a_lowpwr_exit: assert property (data_access_i |=> !low_power_o) else $error("low power kept");
  a_status_bits: assert property (tk && !wb_we_i && wb_adr_i[5:2] == 4'h4 |=> wb_dat_o[7:0] ==
    $past({host_req_i, xfer_dir_i, non_dma_exec_i, cmd_busy_i, seek_busy_i})) else $error("status bad");
  a_tape_floats: assert property (tk && !wb_we_i && wb_adr_i[5:2] == 4'h3 && !enh_mode2_i |=>
    rd_drive_o == 8'h03) else $error("upper tape bits driven");
  // Reset itself is the cause here, so this one is never disabled
  a_hw_reset: assert property (disable iff (1'b0) rst_i |=> data_rate_o == 3'h0 &&
    precomp_steps_o == 8'h03) else $error("reset values wrong");
endmodule // fsr_chk
bind fsr_regs fsr_chk u_chk (.*);

// ### tb/fsr_host.sv
module fsr_host (
  input  wire logic        clk_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [5:0]       adr_o,
  output logic [31:0]      dat_o,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cyc_o, we_o, adr_o, dat_o} = '0;
  // One classic cycle; released data is inverted so stale values never pass
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= (a == 6'h10) ? d & ~32'h20 : d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule // fsr_host

// ### tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc, we, ack, mode2 = 0, ident = 1, dacc = 0, den, lp, srst;
  logic [5:0] adr;
  logic [31:0] wd, rd, q;
  logic [7:0] st = 0, drv, steps, trk;
  logic [2:0] rate;
  logic [1:0] dsel = 0, rsel;
  int mismatches = 0, cmp_count = 0, ticks = 0;
  fsr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .rd_drive_o(drv), .seek_busy_i(st[3:0]),
    .cmd_busy_i(st[4]), .non_dma_exec_i(st[5]), .xfer_dir_i(st[6]), .host_req_i(st[7]), .enh_mode2_i(mode2),
    .ident_i(ident), .drive_sel_i(dsel), .data_access_i(dacc), .dor_reset_i(1'b0), .density_o(den),
    .rate_sel_o(rsel), .data_rate_o(rate), .precomp_steps_o(steps), .precomp_track_o(trk),
    .low_power_o(lp), .soft_reset_o(srst));
  fsr_host h (.clk_i(clk_i), .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wd), .ack_i(ack), .dat_i(rd));
  initial forever #20 clk_i = ~clk_i;
  // Hang guard: the whole run needs well under 3000 cycles
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    h.xfer(1'b1, a, d, q);
  endtask
  // Let registered outputs land, then sample away from the rising edge
  task settle();
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task t_status();
    st <= 8'ha5;
    h.xfer(1'b0, 6'h10, 0, q);
    chk(q[7:0], 8'ha5);
    st <= 8'h5a;
    h.xfer(1'b0, 6'h10, 0, q);
    chk(q[7:0], 8'h5a);
    h.xfer(1'b0, 6'h3c, 0, q);
    chk(q, 0);
  endtask
  // Drive-rate values 0 to 2 with every select, default precompensation code
  task t_rates();
    logic [2:0] er;
    for (int d = 0; d < 3; d++) for (int s = 0; s < 4; s++) begin
      wr(6'h20, d << 8);
      wr(6'h10, s);
      er = (s == 3) ? 3'h3 : (s == 0) ? 3'h2 : (s == 2) ? 3'h0 : (d == 1) ? 3'h2 : (d == 2) ? 3'h4 : 3'h1;
      settle();
      chk({rate, steps, den, rsel}, {er, (er == 3'h3) ? 8'h01 : 8'h03, s == 0 || s == 3, 2'(s)});
    end
    ident <= 1'b0;
    settle();
    chk(den, 1'b0);
    ident <= 1'b1;
  endtask
  task t_precomp();
    for (int c = 1; c < 8; c++) begin
      wr(6'h10, c << 2 | 2);
      settle();
      chk(steps, (c == 7) ? 0 : c);
    end
  endtask
  task t_lastwrite();
    wr(6'h10, 8'h01);
    wr(6'h1c, 8'h03);
    settle();
    chk(rsel, 2'h3);
    wr(6'h10, 8'h02);
    settle();
    chk(rsel, 2'h2);
  endtask
  task t_swreset();
    wr(6'h0c, 8'h02);
    wr(6'h10, 8'h01);
    wr(6'h10, 8'h81);
    settle();
    chk(rsel, 2'h1);
    h.xfer(1'b0, 6'h0c, 0, q);
    chk(q[1:0], 2'h2);
    chk(drv, 8'h03);
  endtask
  task t_lowpower();
    wr(6'h10, 8'h42);
    settle();
    chk(lp, 1'b1);
    h.xfer(1'b0, 6'h10, 0, q);
    settle();
    chk(lp, 1'b0);
    wr(6'h10, 8'h42);
    dacc <= 1'b1;
    @(posedge clk_i);
    dacc <= 1'b0;
    settle();
    chk(lp, 1'b0);
  endtask
  // Mode two: reserved top bits, drive type by last selected drive, boot bits
  task t_mode2();
    mode2 <= 1'b1;
    wr(6'h24, 32'h02e4);
    for (int d = 0; d < 4; d++) begin
      dsel <= d;
      wr(6'h0c, 8'hff);
      h.xfer(1'b0, 6'h0c, 0, q);
      chk(q[7:0], {2'b00, 2'(8'he4 >> (2 * d)), 4'hb});
      chk(drv, 8'hff);
    end
  endtask
  task conclude();
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({rate, steps, den, rsel}, {3'h0, 8'h03, 1'b1, 2'h2});
    t_status();
    t_rates();
    t_precomp();
    t_lastwrite();
    t_swreset();
    t_lowpower();
    t_mode2();
    conclude();
  end
endmodule // testbench
